// File: rtl/htpr_top.sv
// Design decisions made here: the address map and the APB interface to the registers.
`timescale 1ns/100ps
`include "htpr_regs.svh"
module htpr_top
	import htpr_pkg::*;
(
	input  wire logic                      ref_clk,
	input  wire logic                      rstn,
	input  wire logic                      reset_trst_pin,
	input  wire logic                      port_sel_pin,
	input  wire logic                      link_clk,
	input  wire logic                      cs_tms_pin,
	input  wire logic                      shared_serial_in_pin,
	output logic                           shared_serial_out_pin,
	output logic                           shared_serial_out_pin_oe,
	input  wire logic [`HTPR_ERR_W-1:0]    err_detect,
	input  wire logic                      frame_start,
	output logic                           data_error_n,
	output logic                           data_error_n_oe,
	output logic                           loopthrough_out_oe,
	output logic                           func_rst_n,
	input  wire logic [`HTPR_APB_AW-1:0]   paddr,
	input  wire logic                      psel,
	input  wire logic                      penable,
	input  wire logic                      pwrite,
	input  wire logic [31:0]               pwdata,
	output logic [31:0]                    prdata,
	output logic                           pready,
	output logic                           pslverr
);

	localparam int EW = `HTPR_ERR_W;

	logic                      rst_pin_m_q;
	logic                      rst_pin_s_q;
	logic                      sel_m_q;
	logic                      sel_s_q;
	logic [`HTPR_WAIT_W-1:0]   wait_cnt_q;
	logic                      ready_q;
	logic                      func_rst_n_q;
	logic [EW-1:0]             mask_q;
	logic [EW-1:0]             status_q;
	logic [EW-1:0]             status_d;
	logic [EW-1:0]             err_set;
	logic                      err_clr;
	logic                      data_error_n_q;
	logic                      pready_q;
	logic                      pslverr_q;
	logic [31:0]               prdata_q;
	logic                      apb_take;
	logic                      apb_fire;
	logic                      apb_hit;
	logic [31:0]               apb_rd_word;
	logic                      apb_rd_clr;
	logic                      apb_wr_mask;
	logic                      snap_tgl_q;
	logic [2*EW-1:0]           snap_q;
	logic                      ack_m_q;
	logic                      ack_s_q;
	logic                      rdc_m_q;
	logic                      rdc_s_q;
	logic                      rdc_p_q;
	logic                      wr_m_q;
	logic                      wr_s_q;
	logic                      wr_p_q;
	logic                      ser_rd_clr;
	logic                      ser_wr;

	logic                      link_rst_n;
	logic                      lsel_m_q;
	logic                      lsel_s_q;
	logic                      snp_m_q;
	logic                      snp_s_q;
	logic                      ack_tgl_q;
	logic [2*EW-1:0]           shadow_q;
	htpr_ser_e                 ser_state_q;
	logic [3:0]                bit_cnt_q;
	logic [`HTPR_SER_W-1:0]    shift_q;
	logic [`HTPR_SER_W-1:0]    ser_word;
	logic [`HTPR_SER_W-1:0]    rd_word;
	logic                      cmd_rd_q;
	logic [3:0]                cmd_idx_q;
	logic                      ser_on;
	logic                      ser_last;
	logic                      rdc_tgl_q;
	logic                      wr_tgl_q;
	logic [EW-1:0]             wr_data_q;
	logic                      sout_q;
	logic                      sout_oe_q;
	logic                      tap_tdo;
	logic                      tap_tdo_en;

	// pin synchronisers, reference domain
	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			rst_pin_m_q <= 1'h0;
			rst_pin_s_q <= 1'h0;
			sel_m_q     <= 1'h0;
			sel_s_q     <= 1'h0;
		end
		else
		begin
			rst_pin_m_q <= reset_trst_pin;
			rst_pin_s_q <= rst_pin_m_q;
			sel_m_q     <= port_sel_pin;
			sel_s_q     <= sel_m_q;
		end
	end

	// wake-up delay after reset pin release
	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			wait_cnt_q <= `HTPR_WAIT_W'(0);
			ready_q    <= 1'h0;
		end
		else if (!rst_pin_s_q)
		begin
			wait_cnt_q <= `HTPR_WAIT_W'(0);
			ready_q    <= 1'h0;
		end
		else if (!ready_q)
		begin
			if (sel_s_q)
				ready_q <= 1'h1;
			else if (wait_cnt_q == `HTPR_WAIT_W'(`HTPR_WAIT_CYC - 1))
				ready_q <= 1'h1;
			else
				wait_cnt_q <= wait_cnt_q + `HTPR_WAIT_W'(1);
		end
	end

	// functional default and output float
	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
			func_rst_n_q <= 1'h0;
		else
			func_rst_n_q <= ready_q;
	end

	// apb slave, one wait state
	assign apb_take    = psel && penable && !pready_q;
	assign apb_fire    = psel && penable && pready_q;
	assign apb_rd_clr  = apb_take && !pwrite && (paddr == `HTPR_ADDR_STATUS);
	assign apb_wr_mask = apb_fire && pwrite && (paddr == `HTPR_ADDR_MASK);

	always_comb
	begin
		apb_hit     = 1'h1;
		apb_rd_word = 32'h0;
		if (paddr == `HTPR_ADDR_STATUS)
			apb_rd_word = 32'(status_q);
		else if (paddr == `HTPR_ADDR_MASK)
			apb_rd_word = 32'(mask_q);
		else if (paddr == `HTPR_ADDR_PORT)
			apb_rd_word = 32'({ready_q, sel_s_q, rst_pin_s_q});
		else
			apb_hit = 1'h0;
	end

	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			pready_q  <= 1'h0;
			pslverr_q <= 1'h0;
			prdata_q  <= 32'h0;
		end
		else
		begin
			pready_q  <= apb_take;
			pslverr_q <= apb_take && !apb_hit;
			if (apb_take && !pwrite)
				prdata_q <= apb_rd_word;
		end
	end

	// error mask
	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
			mask_q <= `HTPR_ERR_MASK_RST;
		else if (!rst_pin_s_q)
			mask_q <= `HTPR_ERR_MASK_RST;
		else if (apb_wr_mask)
			mask_q <= pwdata[EW-1:0];
		else if (ser_wr)
			mask_q <= wr_data_q;
	end

	// sticky error status, set beats clear
	assign err_set  = err_detect & mask_q & {EW{ready_q}};
	assign err_clr  = frame_start || apb_rd_clr || ser_rd_clr;
	assign status_d = (err_clr ? {EW{1'h0}} : status_q) | err_set;

	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
			status_q <= {EW{1'h0}};
		else if (!rst_pin_s_q)
			status_q <= {EW{1'h0}};
		else
			status_q <= status_d;
	end

	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
			data_error_n_q <= 1'h1;
		else if (!rst_pin_s_q)
			data_error_n_q <= 1'h1;
		else
			data_error_n_q <= ~(|status_d);
	end

	// status and mask snapshot towards the link
	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			ack_m_q    <= 1'h0;
			ack_s_q    <= 1'h0;
			snap_tgl_q <= 1'h0;
			snap_q     <= {(2*EW){1'h0}};
		end
		else
		begin
			ack_m_q <= ack_tgl_q;
			ack_s_q <= ack_m_q;
			if (ack_s_q == snap_tgl_q)
			begin
				snap_q     <= {mask_q, status_q};
				snap_tgl_q <= ~snap_tgl_q;
			end
		end
	end

	// events from the link
	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			rdc_m_q <= 1'h0;
			rdc_s_q <= 1'h0;
			rdc_p_q <= 1'h0;
			wr_m_q  <= 1'h0;
			wr_s_q  <= 1'h0;
			wr_p_q  <= 1'h0;
		end
		else
		begin
			rdc_m_q <= rdc_tgl_q;
			rdc_s_q <= rdc_m_q;
			rdc_p_q <= rdc_s_q;
			wr_m_q  <= wr_tgl_q;
			wr_s_q  <= wr_m_q;
			wr_p_q  <= wr_s_q;
		end
	end

	assign ser_rd_clr = rdc_s_q ^ rdc_p_q;
	assign ser_wr     = wr_s_q ^ wr_p_q;

	// link domain, shared serial clock
	assign link_rst_n = rstn & reset_trst_pin;

	always_ff @(posedge link_clk or negedge link_rst_n)
	begin
		if (!link_rst_n)
		begin
			lsel_m_q <= 1'h0;
			lsel_s_q <= 1'h0;
		end
		else
		begin
			lsel_m_q <= port_sel_pin;
			lsel_s_q <= lsel_m_q;
		end
	end

	always_ff @(posedge link_clk or negedge link_rst_n)
	begin
		if (!link_rst_n)
		begin
			snp_m_q   <= 1'h0;
			snp_s_q   <= 1'h0;
			ack_tgl_q <= 1'h0;
			shadow_q  <= {(2*EW){1'h0}};
		end
		else
		begin
			snp_m_q <= snap_tgl_q;
			snp_s_q <= snp_m_q;
			if (snp_s_q != ack_tgl_q)
			begin
				shadow_q  <= snap_q;
				ack_tgl_q <= snp_s_q;
			end
		end
	end

	// host serial port: cs low selects, 16-bit command then 16-bit data
	assign ser_on   = !lsel_s_q && !cs_tms_pin;
	assign ser_last = ser_on && (bit_cnt_q == `HTPR_SER_LAST);
	assign ser_word = {shift_q[`HTPR_SER_W-2:0], shared_serial_in_pin};

	always_comb
	begin
		if (ser_word[3:0] == `HTPR_IDX_STATUS)
			rd_word = `HTPR_SER_W'(shadow_q[EW-1:0]);
		else if (ser_word[3:0] == `HTPR_IDX_MASK)
			rd_word = `HTPR_SER_W'(shadow_q[2*EW-1:EW]);
		else
			rd_word = `HTPR_SER_W'(0);
	end

	always_ff @(posedge link_clk or negedge link_rst_n)
	begin
		if (!link_rst_n)
		begin
			ser_state_q <= SER_CMD;
			bit_cnt_q   <= 4'h0;
			shift_q     <= `HTPR_SER_W'(0);
			cmd_rd_q    <= 1'h0;
			cmd_idx_q   <= 4'h0;
		end
		else if (!ser_on)
		begin
			ser_state_q <= SER_CMD;
			bit_cnt_q   <= 4'h0;
		end
		else
		begin
			shift_q   <= ser_word;
			bit_cnt_q <= bit_cnt_q + 4'h1;
			if (ser_last)
			begin
				case (ser_state_q)
					SER_CMD:
					begin
						ser_state_q <= SER_DATA;
						cmd_rd_q    <= ser_word[`HTPR_SER_RD_BIT];
						cmd_idx_q   <= ser_word[3:0];
						if (ser_word[`HTPR_SER_RD_BIT])
							shift_q <= rd_word;
					end
					default:
						ser_state_q <= SER_CMD;
				endcase
			end
		end
	end

	// host side register effects
	always_ff @(posedge link_clk or negedge link_rst_n)
	begin
		if (!link_rst_n)
		begin
			rdc_tgl_q <= 1'h0;
			wr_tgl_q  <= 1'h0;
			wr_data_q <= {EW{1'h0}};
		end
		else if (ser_last && ser_state_q == SER_CMD)
		begin
			if (ser_word[`HTPR_SER_RD_BIT] && ser_word[3:0] == `HTPR_IDX_STATUS)
				rdc_tgl_q <= ~rdc_tgl_q;
		end
		else if (ser_last && !cmd_rd_q && cmd_idx_q == `HTPR_IDX_MASK)
		begin
			wr_data_q <= ser_word[EW-1:0];
			wr_tgl_q  <= ~wr_tgl_q;
		end
	end

	// scan port
	htpr_tap u_tap (
		.tck      (link_clk),
		.trst_n   (link_rst_n),
		.hold_rst (!lsel_s_q),
		.tms      (cs_tms_pin),
		.tdi      (shared_serial_in_pin),
		.tdo      (tap_tdo),
		.tdo_en   (tap_tdo_en)
	);

	// shared output pin, updated on falling clock
	always_ff @(negedge link_clk or negedge link_rst_n)
	begin
		if (!link_rst_n)
		begin
			sout_q    <= 1'h0;
			sout_oe_q <= 1'h0;
		end
		else if (lsel_s_q)
		begin
			sout_q    <= tap_tdo;
			sout_oe_q <= tap_tdo_en;
		end
		else
		begin
			sout_q    <= shift_q[`HTPR_SER_W-1];
			sout_oe_q <= !cs_tms_pin && cmd_rd_q && ser_state_q == SER_DATA;
		end
	end

	assign shared_serial_out_pin    = sout_q;
	assign shared_serial_out_pin_oe = sout_oe_q;
	assign data_error_n             = data_error_n_q;
	assign data_error_n_oe          = func_rst_n_q;
	assign loopthrough_out_oe       = func_rst_n_q;
	assign func_rst_n               = func_rst_n_q;
	assign prdata                   = prdata_q;
	assign pready                   = pready_q;
	assign pslverr                  = pslverr_q;

endmodule : htpr_top

// File: rtl/htpr_regs.svh
`ifndef HTPR_REGS_SVH
`define HTPR_REGS_SVH
// Summary of operation
// - In host mode a low reset pin returns all logic to defaults and floats every output; the APB slave is not reset and prdata, pready, pslverr stay driven.
// - In host mode normal operation resumes 10 us after the reset pin rises.
// - In test mode a low reset pin defaults all logic and holds the scan port in reset; the APB slave is not reset by the pin and keeps answering.
// - A high port select routes the shared pins to the boundary-scan port.
// - A low port select runs the shared pins as the serial host register port.
// - The shared select pin is an active-low chip select in host mode, active-high TMS in test.
// - The shared output pin returns register contents in host mode and TDO in test mode.
// - Command and data words are captured on the shared serial clock, which is TCK in test.
// - The error output is driven low as the OR of all enabled detected errors.
// - A low error output holds until the next frame or field or a read of the error status.
// - The error output stays high while the stream is checked without error.
// - Only errors whose mask bits are high are monitored, and all are monitored after reset.

`define HTPR_ERR_W        5
`define HTPR_ERR_MASK_RST 5'h1f
`define HTPR_APB_AW       12
`define HTPR_ADDR_STATUS  12'h000
`define HTPR_ADDR_MASK    12'h004
`define HTPR_ADDR_PORT    12'h008
`define HTPR_REF_MHZ      100
`define HTPR_WAIT_NS      10000
`define HTPR_WAIT_CYC     ((`HTPR_WAIT_NS * `HTPR_REF_MHZ + 999) / 1000)
`define HTPR_WAIT_W       11
`define HTPR_SER_W        16
`define HTPR_SER_LAST     4'hf
`define HTPR_SER_RD_BIT   15
`define HTPR_IDX_STATUS   4'h0
`define HTPR_IDX_MASK     4'h1
`define HTPR_IR_W         4
`define HTPR_IR_BYPASS    4'hf
`define HTPR_IR_IDCODE    4'h1
`define HTPR_IR_CAPT      4'h5
`endif

// File: rtl/htpr_pkg.sv
package htpr_pkg;

	typedef enum logic [3:0] {
		TAP_RESET,
		TAP_IDLE,
		TAP_SEL_DR,
		TAP_CAP_DR,
		TAP_SHIFT_DR,
		TAP_EXIT1_DR,
		TAP_PAUSE_DR,
		TAP_EXIT2_DR,
		TAP_UPD_DR,
		TAP_SEL_IR,
		TAP_CAP_IR,
		TAP_SHIFT_IR,
		TAP_EXIT1_IR,
		TAP_PAUSE_IR,
		TAP_EXIT2_IR,
		TAP_UPD_IR
	} htpr_tap_e;

	typedef enum logic {
		SER_CMD,
		SER_DATA
	} htpr_ser_e;

endpackage : htpr_pkg

// File: rtl/htpr_tap.sv
`timescale 1ns/100ps
`include "htpr_regs.svh"
module htpr_tap
	import htpr_pkg::*;
#(
	parameter logic [31:0] ID_VALUE = 32'h0000_0001 // arbitrary value
)
(
	input  wire logic tck,
	input  wire logic trst_n,
	input  wire logic hold_rst,
	input  wire logic tms,
	input  wire logic tdi,
	output logic      tdo,
	output logic      tdo_en
);

	htpr_tap_e                state_q;
	htpr_tap_e                state_d;
	logic [`HTPR_IR_W-1:0]    ir_sh_q;
	logic [`HTPR_IR_W-1:0]    ir_q;
	logic                     byp_q;
	logic [31:0]              id_q;

	always_comb
	begin
		state_d = state_q;
		case (state_q)
			TAP_RESET:    state_d = tms ? TAP_RESET : TAP_IDLE;
			TAP_IDLE:     state_d = tms ? TAP_SEL_DR : TAP_IDLE;
			TAP_SEL_DR:   state_d = tms ? TAP_SEL_IR : TAP_CAP_DR;
			TAP_CAP_DR:   state_d = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
			TAP_SHIFT_DR: state_d = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
			TAP_EXIT1_DR: state_d = tms ? TAP_UPD_DR : TAP_PAUSE_DR;
			TAP_PAUSE_DR: state_d = tms ? TAP_EXIT2_DR : TAP_PAUSE_DR;
			TAP_EXIT2_DR: state_d = tms ? TAP_UPD_DR : TAP_SHIFT_DR;
			TAP_UPD_DR:   state_d = tms ? TAP_SEL_DR : TAP_IDLE;
			TAP_SEL_IR:   state_d = tms ? TAP_RESET : TAP_CAP_IR;
			TAP_CAP_IR:   state_d = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
			TAP_SHIFT_IR: state_d = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
			TAP_EXIT1_IR: state_d = tms ? TAP_UPD_IR : TAP_PAUSE_IR;
			TAP_PAUSE_IR: state_d = tms ? TAP_EXIT2_IR : TAP_PAUSE_IR;
			TAP_EXIT2_IR: state_d = tms ? TAP_UPD_IR : TAP_SHIFT_IR;
			TAP_UPD_IR:   state_d = tms ? TAP_SEL_DR : TAP_IDLE;
			default:      state_d = TAP_RESET;
		endcase
	end

	// tms sampled on rising tck
	always_ff @(posedge tck or negedge trst_n)
	begin
		if (!trst_n)
			state_q <= TAP_RESET;
		else if (hold_rst)
			state_q <= TAP_RESET;
		else
			state_q <= state_d;
	end

	always_ff @(posedge tck or negedge trst_n)
	begin
		if (!trst_n)
		begin
			ir_sh_q <= `HTPR_IR_W'(0);
			ir_q    <= `HTPR_IR_IDCODE;
		end
		else if (hold_rst || state_q == TAP_RESET)
			ir_q <= `HTPR_IR_IDCODE;
		else if (state_q == TAP_CAP_IR)
			ir_sh_q <= `HTPR_IR_CAPT;
		else if (state_q == TAP_SHIFT_IR)
			ir_sh_q <= {tdi, ir_sh_q[`HTPR_IR_W-1:1]};
		else if (state_q == TAP_UPD_IR)
			ir_q <= ir_sh_q;
	end

	always_ff @(posedge tck or negedge trst_n)
	begin
		if (!trst_n)
		begin
			byp_q <= 1'h0;
			id_q  <= 32'h0;
		end
		else if (state_q == TAP_CAP_DR)
		begin
			byp_q <= 1'h0;
			id_q  <= ID_VALUE;
		end
		else if (state_q == TAP_SHIFT_DR)
		begin
			byp_q <= tdi;
			id_q  <= {tdi, id_q[31:1]};
		end
	end

	always_comb
	begin
		tdo_en = (state_q == TAP_SHIFT_IR) || (state_q == TAP_SHIFT_DR);
		if (state_q == TAP_SHIFT_IR)
			tdo = ir_sh_q[0];
		else if (ir_q == `HTPR_IR_IDCODE)
			tdo = id_q[0];
		else
			tdo = byp_q;
	end

endmodule : htpr_tap

// File: verification/htpr_chk_asserts.sv
`timescale 1ns/100ps
`include "htpr_regs.svh"
module htpr_chk
(
	input wire logic			ref_clk,
	input wire logic			rstn,
	input wire logic			reset_trst_pin,
	input wire logic			port_sel_pin,
	input wire logic			link_clk,
	input wire logic			cs_tms_pin,
	input wire logic			shared_serial_out_pin_oe,
	input wire logic [`HTPR_ERR_W-1:0]	err_detect,
	input wire logic			frame_start,
	input wire logic			data_error_n,
	input wire logic			data_error_n_oe,
	input wire logic			loopthrough_out_oe,
	input wire logic			func_rst_n,
	input wire logic [`HTPR_APB_AW-1:0]	paddr,
	input wire logic			psel,
	input wire logic			penable,
	input wire logic			pwrite,
	input wire logic			pready,
	input wire logic			pslverr
);
	logic [10:0]	hi_cnt_q;
	logic		dirty_q;
	logic		rd_stat;
	logic		clr;

	assign rd_stat = psel && penable && !pready && !pwrite && paddr == `HTPR_ADDR_STATUS;
	assign clr = frame_start || rd_stat || !cs_tms_pin || !reset_trst_pin;

	// cycles since the reset pin went high
	always_ff @(posedge ref_clk or negedge rstn)
		if (!rstn)
			hi_cnt_q <= 11'h000;
		else if (!reset_trst_pin)
			hi_cnt_q <= 11'h000;
		else if (hi_cnt_q != 11'h7ff)
			hi_cnt_q <= hi_cnt_q + 11'h001;

	// mask may have left its reset value
	always_ff @(posedge ref_clk or negedge rstn)
		if (!rstn)
			dirty_q <= 1'b0;
		else if ((psel && pwrite && paddr == `HTPR_ADDR_MASK) || !cs_tms_pin)
			dirty_q <= 1'b1;

	chk_err_set: assert property (@(posedge ref_clk) disable iff (!rstn)
		!dirty_q && func_rst_n && reset_trst_pin && err_detect != 5'h00
		|-> ##[1:2] !data_error_n) else $error("error flag missed an error");
	chk_err_hold: assert property (@(posedge ref_clk) disable iff (!rstn)
		!data_error_n && !clr && !$past(clr) |=> !data_error_n)
		else $error("error flag released early");
	chk_frame_clr: assert property (@(posedge ref_clk) disable iff (!rstn)
		frame_start && err_detect == 5'h00 |-> ##[1:2] data_error_n)
		else $error("frame start did not clear flag");
	chk_read_clr: assert property (@(posedge ref_clk) disable iff (!rstn)
		rd_stat && err_detect == 5'h00 |-> ##[1:2] data_error_n)
		else $error("status read did not clear flag");
	chk_rst_float: assert property (@(posedge ref_clk) disable iff (!rstn)
		!reset_trst_pin [*5] |-> !func_rst_n && !loopthrough_out_oe && !data_error_n_oe
		&& data_error_n) else $error("outputs not defaulted in reset");
	chk_resume_host: assert property (@(posedge ref_clk) disable iff (!rstn)
		$rose(func_rst_n) && !port_sel_pin |-> hi_cnt_q >= 11'h3e8 && hi_cnt_q <= 11'h3f2)
		else $error("host resume time wrong");
	chk_resume_test: assert property (@(posedge ref_clk) disable iff (!rstn)
		$rose(func_rst_n) && port_sel_pin |-> hi_cnt_q <= 11'h008)
		else $error("test resume too slow");
	chk_oe_follow: assert property (@(posedge ref_clk) disable iff (!rstn)
		$rose(func_rst_n) |-> ##[0:1] (data_error_n_oe && loopthrough_out_oe))
		else $error("drivers not enabled on resume");
	chk_apb_wait: assert property (@(posedge ref_clk) disable iff (!rstn)
		psel && penable && !pready |=> pready ##1 !pready)
		else $error("apb wait state wrong");
	chk_host_quiet: assert property (@(posedge link_clk) disable iff (!rstn)
		(!port_sel_pin && cs_tms_pin) [*2] |-> !shared_serial_out_pin_oe)
		else $error("serial out driven while deselected");
	chk_tap_hold: assert property (@(posedge link_clk) disable iff (!rstn)
		!reset_trst_pin |-> !shared_serial_out_pin_oe)
		else $error("serial out driven in reset");

	cov_err: cover property (@(posedge ref_clk) $fell(data_error_n));
	cov_bad: cover property (@(posedge ref_clk) pready && pslverr);
	cov_sdo: cover property (@(posedge link_clk) shared_serial_out_pin_oe);
endmodule : htpr_chk

bind htpr_top htpr_chk u_chk (
	.ref_clk(ref_clk), .rstn(rstn), .reset_trst_pin(reset_trst_pin),
	.port_sel_pin(port_sel_pin), .link_clk(link_clk), .cs_tms_pin(cs_tms_pin),
	.shared_serial_out_pin_oe(shared_serial_out_pin_oe), .err_detect(err_detect),
	.frame_start(frame_start), .data_error_n(data_error_n),
	.data_error_n_oe(data_error_n_oe), .loopthrough_out_oe(loopthrough_out_oe),
	.func_rst_n(func_rst_n), .paddr(paddr), .psel(psel), .penable(penable),
	.pwrite(pwrite), .pready(pready), .pslverr(pslverr)
);

// File: verification/htpr_host_model.sv
`timescale 1ns/100ps
module htpr_host_model
(
	output logic		link_clk,
	output logic		cs_tms_pin,
	output logic		shared_serial_in_pin,
	input wire logic	shared_serial_out_pin,
	input wire logic	shared_serial_out_pin_oe
);
	// clock stands still between bursts
	initial
	begin
		link_clk = 1'b0;
		cs_tms_pin = 1'b1;
		shared_serial_in_pin = 1'b0;
	end

	// one 6 ns period, output sampled just before the rising edge
	task tick(input logic sel, input logic di, output logic dv, output logic ov);
		cs_tms_pin = sel;
		shared_serial_in_pin = di;
		#3;
		dv = shared_serial_out_pin;
		ov = shared_serial_out_pin_oe;
		link_clk = 1'b1;
		#3;
		link_clk = 1'b0;
	endtask : tick

	// command then data word, msb first, chip select low
	task xfer(input logic [31:0] bits, output logic [15:0] rd, output logic ok);
		logic d;
		logic o;
		ok = 1'b1;
		for (int i = 31; i >= 0; i--)
		begin
			tick(1'b0, bits[i], d, o);
			if (i < 16)
			begin
				rd[i] = d;
				ok = ok && o;
			end
		end
		cs_tms_pin = 1'b1;
		shared_serial_in_pin = ~bits[0];
	endtask : xfer
endmodule : htpr_host_model

// File: verification/host_test_port_reset_and_error_flag_test.sv
`timescale 1ns/100ps
`include "htpr_regs.svh"
module host_test_port_reset_and_error_flag_test;
	localparam logic [8:0] TMS_SEQ = 9'h106;

	logic				ref_clk;
	logic				rstn;
	logic				reset_trst_pin;
	logic				port_sel_pin;
	logic [`HTPR_ERR_W-1:0]		err_detect;
	logic				frame_start;
	logic [`HTPR_APB_AW-1:0]	paddr;
	logic				psel;
	logic				penable;
	logic				pwrite;
	logic [31:0]			pwdata;
	logic [31:0]			prdata;
	logic				pready;
	logic				pslverr;
	logic				link_clk;
	logic				cs_tms_pin;
	logic				sdi;
	logic				loopthrough_out;
	logic				sdo_oe;
	logic				data_error_n;
	logic				data_error_n_oe;
	logic				lt_oe;
	logic				func_rst_n;
	logic [31:0]			got;
	logic [15:0]			v16;
	logic				ok;
	int				errors;
	int				compares;
	int				cycles;

	htpr_top dut (
		.ref_clk(ref_clk), .rstn(rstn), .reset_trst_pin(reset_trst_pin),
		.port_sel_pin(port_sel_pin), .link_clk(link_clk), .cs_tms_pin(cs_tms_pin),
		.shared_serial_in_pin(sdi), .shared_serial_out_pin(loopthrough_out),
		.shared_serial_out_pin_oe(sdo_oe), .err_detect(err_detect),
		.frame_start(frame_start), .data_error_n(data_error_n),
		.data_error_n_oe(data_error_n_oe), .loopthrough_out_oe(lt_oe),
		.func_rst_n(func_rst_n), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr)
	);

	htpr_host_model u_host (
		.link_clk(link_clk), .cs_tms_pin(cs_tms_pin), .shared_serial_in_pin(sdi),
		.shared_serial_out_pin(loopthrough_out), .shared_serial_out_pin_oe(sdo_oe)
	);

	always #5 ref_clk = ~ref_clk;

	task end_sim;
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : end_sim

	always @(posedge ref_clk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			errors++;
			$display("[FAIL] %0t run did not finish", $time);
			end_sim;
		end
	end

	task chk(input logic [31:0] g, input logic [31:0] exp);
		compares++;
		if (g !== exp)
		begin
			errors++;
			$display("[FAIL] %0t got %h want %h", $time, g, exp);
		end
	endtask : chk

	task cyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask : cyc

	// one apb transfer, held until pready; read expects d
	task acc(input logic w, input logic [`HTPR_APB_AW-1:0] a, input logic [31:0] d,
		input logic e_exp);
		@(posedge ref_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do
			@(posedge ref_clk);
		while (pready !== 1'b1);
		got = prdata;
		chk(32'(pslverr), 32'(e_exp));
		if (!w)
			chk(got, d);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : acc

	task pulse(input logic [4:0] v, input logic f);
		@(posedge ref_clk);
		err_detect <= v;
		frame_start <= f;
		@(posedge ref_clk);
		err_detect <= 5'h00;
		frame_start <= 1'b0;
		cyc(3);
	endtask : pulse

	// tap reset, walk to shift-ir and shift out the capture pattern
	task scan(input logic live);
		logic d;
		logic o;
		logic [3:0] cap;
		cap = `HTPR_IR_CAPT;
		repeat (5) u_host.tick(1'b1, 1'b1, d, o);
		for (int i = 0; i < 9; i++)
		begin
			u_host.tick(TMS_SEQ[i], 1'b1, d, o);
			if (i > 4)
				chk(32'({d && live, o}), 32'({cap[i - 5] && live, live}));
		end
	endtask : scan

	initial
	begin
		ref_clk = 1'b0;
		rstn = 1'b0;
		reset_trst_pin = 1'b1;
		port_sel_pin = 1'b0;
		err_detect = 5'h00;
		frame_start = 1'b0;
		paddr = 12'h000;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		pwdata = 32'h0000_0000;
		errors = 0;
		compares = 0;
		cycles = 0;
		cyc(12);
		rstn <= 1'b1;
		cyc(1100);
		chk(32'({func_rst_n, data_error_n_oe, lt_oe, data_error_n}), 32'hf);
		acc(1'b0, `HTPR_ADDR_MASK, 32'h1f, 1'b0);
		acc(1'b0, `HTPR_ADDR_PORT, 32'h5, 1'b0);
		acc(1'b0, 12'h00c, 32'h0, 1'b1);
		acc(1'b1, `HTPR_ADDR_STATUS, 32'h1f, 1'b0);
		acc(1'b0, `HTPR_ADDR_STATUS, 32'h0, 1'b0);
		pulse(5'h04, 1'b0);
		chk(32'(data_error_n), 32'h0);
		cyc(20);
		chk(32'(data_error_n), 32'h0);
		pulse(5'h00, 1'b1);
		chk(32'(data_error_n), 32'h1);
		pulse(5'h01, 1'b0);
		acc(1'b0, `HTPR_ADDR_STATUS, 32'h1, 1'b0);
		cyc(2);
		chk(32'(data_error_n), 32'h1);
		acc(1'b0, `HTPR_ADDR_STATUS, 32'h0, 1'b0);
		acc(1'b1, `HTPR_ADDR_MASK, 32'h1e, 1'b0);
		pulse(5'h01, 1'b0);
		chk(32'(data_error_n), 32'h1);
		pulse(5'h10, 1'b0);
		chk(32'(data_error_n), 32'h0);
		acc(1'b0, `HTPR_ADDR_STATUS, 32'h10, 1'b0);
		u_host.xfer({16'h8001, 16'h0000}, v16, ok);
		chk({ok, 15'h0, v16}, {1'b1, 15'h0, 16'h001e});
		u_host.xfer({16'h0001, 16'h0007}, v16, ok);
		cyc(10);
		acc(1'b0, `HTPR_ADDR_MASK, 32'h7, 1'b0);
		pulse(5'h02, 1'b0);
		u_host.xfer({16'h8000, 16'h0000}, v16, ok);
		cyc(10);
		chk({ok, data_error_n, 14'h0, v16}, {2'b11, 14'h0, 16'h0002});
		repeat (2) u_host.tick(1'b1, 1'b0, v16[0], ok);
		chk(32'(ok), 32'h0);
		reset_trst_pin <= 1'b0;
		cyc(6);
		chk(32'({func_rst_n, data_error_n_oe, lt_oe, sdo_oe}), 32'h0);
		acc(1'b0, `HTPR_ADDR_MASK, 32'h1f, 1'b0);
		reset_trst_pin <= 1'b1;
		cyc(990);
		chk(32'(func_rst_n), 32'h0);
		cyc(20);
		chk(32'({func_rst_n, data_error_n_oe, lt_oe}), 32'h7);
		port_sel_pin <= 1'b1;
		cyc(5);
		acc(1'b0, `HTPR_ADDR_PORT, 32'h7, 1'b0);
		scan(1'b1);
		cyc(1);
		reset_trst_pin <= 1'b0;
		cyc(6);
		chk(32'(func_rst_n), 32'h0);
		scan(1'b0);
		cyc(1);
		reset_trst_pin <= 1'b1;
		cyc(10);
		chk(32'(func_rst_n), 32'h1);
		scan(1'b1);
		end_sim;
	end
endmodule : host_test_port_reset_and_error_flag_test
